// *** hw/gfp_defines.svh ***
// Register map, field positions, reset values and constants of the GCM fragment engine
`ifndef GFP_DEFINES_SVH
`define GFP_DEFINES_SVH

`define GFP_A_MODE      8'h00
`define GFP_A_CTRL      8'h04
`define GFP_A_STAT      8'h08
`define GFP_A_IMASK     8'h0c
`define GFP_A_AUTH_DATA_LENGTH_FIELD    8'h10
`define GFP_A_TEXT_LENGTH_FIELD      8'h14
`define GFP_A_CTR       8'h18
`define GFP_G_KEY       4'h2
`define GFP_G_IV        4'h3
`define GFP_G_INPUT_DATA_FIELD     4'h4
`define GFP_G_ODATA     4'h5
`define GFP_G_HASH_STATE_VALUE     4'h6
`define GFP_G_HSUB      4'h7

`define GFP_MODE_GCM    0
`define GFP_MODE_TAG    1
`define GFP_MODE_ENC    2
`define GFP_MODE_START_MODE_FIELD   3
`define GFP_CTRL_START  0

`define GFP_MODE_RST    4'h0
`define GFP_BLK_BYTES   32'h0000_0010
`define GFP_TAG_CTR     32'h0000_0001
`define GFP_GF_POLY     {8'he1, 120'h0}
`define GFP_MULT_BITS   7'h7f

`endif

// *** hw/gfp_pkg.sv ***
// Types shared by the GCM fragment engine
package gfp_pkg;
    typedef logic [7:0]   gfp_addr_t;
    typedef logic [31:0]  gfp_word_t;
    typedef logic [127:0] gfp_block_t;
    typedef enum {ST_IDLE, ST_KEY, ST_BLOCK, ST_WAIT, ST_LEN} gfp_state_e;
endpackage

// *** hw/gfp_mult_if.sv ***
// Carrier between the engine control and the hash multiplier
`timescale 1ns/1ps
interface gfp_mult_if;
    import gfp_pkg::*;
    logic       start;
    gfp_block_t x;
    gfp_block_t h;
    gfp_block_t y;
    logic       done;
    modport ctl (output start, x, h, input y, done);
    modport eng (input start, x, h, output y, done);
endinterface

// *** hw/gfp_hash_state_value_mult.sv ***
// Bit-serial multiply in the hash field, one bit of X per clock
`timescale 1ns/1ps
module gfp_hash_state_value_mult (
    input  wire logic  clk,
    input  wire logic  rst,
    gfp_mult_if.eng    mif
);
    import gfp_pkg::*;
    `include "gfp_defines.svh"

    gfp_block_t z_reg, z_next, v_reg, v_next, x_reg, x_next;
    logic [6:0] cnt_reg, cnt_next;
    logic       busy_reg, busy_next, done_reg, done_next;

    assign mif.y    = z_reg;
    assign mif.done = done_reg;

    always_comb begin
        z_next    = z_reg;
        v_next    = v_reg;
        x_next    = x_reg;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (mif.start) begin
            z_next    = '0;
            v_next    = mif.h;
            x_next    = mif.x;
            cnt_next  = '0;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (x_reg[127])
                z_next = z_reg ^ v_reg;
            v_next   = v_reg[0] ? ((v_reg >> 1) ^ `GFP_GF_POLY) : (v_reg >> 1);
            x_next   = x_reg << 1;
            cnt_next = cnt_reg + 7'h01;
            if (cnt_reg == `GFP_MULT_BITS) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            z_reg    <= '0;
            v_reg    <= '0;
            x_reg    <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            z_reg    <= z_next;
            v_reg    <= v_next;
            x_reg    <= x_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    a_mult_latency: assert property (@(posedge clk) disable iff (rst)
        mif.start |-> ##129 mif.done)
        else $error("hash multiply did not finish in 129 cycles");
endmodule

// *** hw/gfp_engine.sv ***
// GCM engine that resumes hashing and counting across message fragments
// How it works
// - Key load derives subkey, raises data ready
// - Processed input block raises data ready
// - Authenticated-data blocks only update hash
// - Hash and counter registers hold running state
// - Fragment or remaining length both work
// - 0x10 and zero lengths, tag bit off: one pass
`timescale 1ns/1ps
module gfp_engine (
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire gfp_pkg::gfp_addr_t ADDR,
    input  wire gfp_pkg::gfp_word_t WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output gfp_pkg::gfp_word_t    RDATA,
    output logic                  IRQ
);
    import gfp_pkg::*;
    `include "gfp_defines.svh"

    gfp_mult_if mif ();

    gfp_state_e st_reg, st_next;
    logic [3:0] mode_reg, mode_next;
    logic       dready_reg, dready_next, imask_reg, imask_next, irq_reg, irq_next;
    logic       go_reg, go_next, tag_done_reg, tag_done_next;
    gfp_word_t  auth_data_length_field_reg, auth_data_length_field_next, text_length_field_reg, text_length_field_next, ctr_reg, ctr_next;
    gfp_word_t  aad_cnt_reg, aad_cnt_next, c_cnt_reg, c_cnt_next, rdata_reg, rdata_next;
    gfp_block_t key_reg, key_next, iv_reg, iv_next, input_data_field_reg, input_data_field_next;
    gfp_block_t odata_reg, odata_next, hash_state_value_reg, hash_state_value_next, hsub_reg, hsub_next;
    gfp_block_t x_reg, x_next, ks, ct;
    logic       is_aad, wr_last, key_trig;
    logic [1:0] wi;

    // Stand-in keyed permutation; the block cipher core plugs in here
    function automatic gfp_block_t blk_enc(input gfp_block_t k, input gfp_block_t d);
        gfp_block_t r;
        r = d ^ k;
        r = r ^ {r[102:0], r[127:103]} ^ {k[63:0], k[127:64]};
        return r ^ {r[58:0], r[127:59]};
    endfunction

    function automatic gfp_block_t put_w(input gfp_block_t v, input logic [1:0] i,
                                         input gfp_word_t d);
        gfp_block_t r;
        r = v;
        r[(3 - i) * 32 +: 32] = d;
        return r;
    endfunction

    function automatic gfp_word_t get_w(input gfp_block_t v, input logic [1:0] i);
        return v[(3 - i) * 32 +: 32];
    endfunction

    assign wi       = ADDR[3:2];
    assign wr_last  = WR && (wi == 2'd3);
    assign key_trig = wr_last && (ADDR[7:4] == `GFP_G_KEY);
    assign is_aad   = aad_cnt_reg < auth_data_length_field_reg;
    assign ks       = blk_enc(key_reg, {iv_reg[127:32], ctr_reg});
    assign ct       = input_data_field_reg ^ ks;
    assign mif.start = go_reg;
    assign mif.x     = x_reg;
    assign mif.h     = hsub_reg;
    assign RDATA     = rdata_reg;
    assign IRQ       = irq_reg;

    gfp_hash_state_value_mult u_mult (
        .clk (CLK),
        .rst (RST),
        .mif (mif)
    );

    always_comb begin
        st_next       = st_reg;
        mode_next     = mode_reg;
        dready_next   = dready_reg;
        imask_next    = imask_reg;
        go_next       = 1'b0;
        tag_done_next = tag_done_reg;
        auth_data_length_field_next   = auth_data_length_field_reg;
        text_length_field_next     = text_length_field_reg;
        ctr_next      = ctr_reg;
        aad_cnt_next  = aad_cnt_reg;
        c_cnt_next    = c_cnt_reg;
        key_next      = key_reg;
        iv_next       = iv_reg;
        input_data_field_next    = input_data_field_reg;
        odata_next    = odata_reg;
        hash_state_value_next    = hash_state_value_reg;
        hsub_next     = hsub_reg;
        x_next        = x_reg;
        rdata_next    = '0;
        // Read side: a status read clears the flag, a same-cycle set below still wins
        if (RD) begin
            case (ADDR)
                `GFP_A_MODE:   rdata_next = {28'h0, mode_reg};
                `GFP_A_STAT: begin
                    rdata_next  = {31'h0, dready_reg};
                    dready_next = 1'b0;
                end
                `GFP_A_IMASK:  rdata_next = {31'h0, imask_reg};
                `GFP_A_AUTH_DATA_LENGTH_FIELD: rdata_next = auth_data_length_field_reg;
                `GFP_A_TEXT_LENGTH_FIELD:   rdata_next = text_length_field_reg;
                `GFP_A_CTR:    rdata_next = ctr_reg;
                default: begin
                    case (ADDR[7:4])
                        `GFP_G_IV:    rdata_next = get_w(iv_reg, wi);
                        `GFP_G_ODATA: rdata_next = get_w(odata_reg, wi);
                        `GFP_G_HASH_STATE_VALUE: rdata_next = get_w(hash_state_value_reg, wi);
                        `GFP_G_HSUB:  rdata_next = get_w(hsub_reg, wi);
                        default:      rdata_next = '0;
                    endcase
                end
            endcase
        end
        // Writes land in any state; software keeps the ordering
        if (WR) begin
            case (ADDR)
                `GFP_A_MODE:   mode_next   = WDATA[3:0];
                `GFP_A_IMASK:  imask_next  = WDATA[0];
                `GFP_A_AUTH_DATA_LENGTH_FIELD: auth_data_length_field_next = WDATA;
                `GFP_A_TEXT_LENGTH_FIELD:   text_length_field_next   = WDATA;
                default: begin
                    case (ADDR[7:4])
                        `GFP_G_KEY:   key_next   = put_w(key_reg, wi, WDATA);
                        `GFP_G_IV:    iv_next    = put_w(iv_reg, wi, WDATA);
                        `GFP_G_INPUT_DATA_FIELD: input_data_field_next = put_w(input_data_field_reg, wi, WDATA);
                        `GFP_G_HASH_STATE_VALUE: hash_state_value_next = put_w(hash_state_value_reg, wi, WDATA);
                        `GFP_G_HSUB:  hsub_next  = put_w(hsub_reg, wi, WDATA);
                        default:      ;
                    endcase
                end
            endcase
        end
        // Full IV write starts a fragment: counter from its low word, phase counts cleared
        if (wr_last && ADDR[7:4] == `GFP_G_IV) begin
            ctr_next      = WDATA;
            aad_cnt_next  = '0;
            c_cnt_next    = '0;
            tag_done_next = 1'b0;
        end
        case (st_reg)
            ST_IDLE: begin
                if (key_trig)
                    st_next = ST_KEY;
                else if ((WR && ADDR == `GFP_A_CTRL && WDATA[`GFP_CTRL_START] &&
                          !mode_reg[`GFP_MODE_START_MODE_FIELD]) ||
                         (wr_last && ADDR[7:4] == `GFP_G_INPUT_DATA_FIELD && mode_reg[`GFP_MODE_START_MODE_FIELD]))
                    st_next = ST_BLOCK;
            end
            ST_KEY: begin
                hsub_next   = blk_enc(key_reg, '0);
                dready_next = 1'b1;
                st_next     = ST_IDLE;
            end
            ST_BLOCK: begin
                if (is_aad || !mode_reg[`GFP_MODE_GCM]) begin
                    x_next       = hash_state_value_reg ^ input_data_field_reg;
                    aad_cnt_next = aad_cnt_reg + `GFP_BLK_BYTES;
                end else begin
                    odata_next = ct;
                    ctr_next   = ctr_reg + 32'h1;
                    x_next     = hash_state_value_reg ^ (mode_reg[`GFP_MODE_ENC] ? ct : input_data_field_reg);
                    c_cnt_next = c_cnt_reg + `GFP_BLK_BYTES;
                end
                go_next = 1'b1;
                st_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (mif.done) begin
                    hash_state_value_next = mif.y;
                    if (mode_reg[`GFP_MODE_TAG] && !tag_done_reg && !is_aad &&
                        c_cnt_reg >= text_length_field_reg) begin
                        x_next  = mif.y ^ {29'h0, auth_data_length_field_reg, 3'h0, 29'h0, text_length_field_reg, 3'h0};
                        go_next = 1'b1;
                        st_next = ST_LEN;
                    end else begin
                        dready_next = 1'b1;
                        st_next     = ST_IDLE;
                    end
                end
            end
            ST_LEN: begin
                if (mif.done) begin
                    hash_state_value_next    = mif.y;
                    odata_next    = mif.y ^ blk_enc(key_reg, {iv_reg[127:32], `GFP_TAG_CTR});
                    tag_done_next = 1'b1;
                    dready_next   = 1'b1;
                    st_next       = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        irq_next = dready_next && imask_next;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_reg       <= ST_IDLE;
            mode_reg     <= `GFP_MODE_RST;
            dready_reg   <= 1'b0;
            imask_reg    <= 1'b0;
            irq_reg      <= 1'b0;
            go_reg       <= 1'b0;
            tag_done_reg <= 1'b0;
            auth_data_length_field_reg   <= '0;
            text_length_field_reg     <= '0;
            ctr_reg      <= '0;
            aad_cnt_reg  <= '0;
            c_cnt_reg    <= '0;
            rdata_reg    <= '0;
            key_reg      <= '0;
            iv_reg       <= '0;
            input_data_field_reg    <= '0;
            odata_reg    <= '0;
            hash_state_value_reg    <= '0;
            hsub_reg     <= '0;
            x_reg        <= '0;
        end else begin
            st_reg       <= st_next;
            mode_reg     <= mode_next;
            dready_reg   <= dready_next;
            imask_reg    <= imask_next;
            irq_reg      <= irq_next;
            go_reg       <= go_next;
            tag_done_reg <= tag_done_next;
            auth_data_length_field_reg   <= auth_data_length_field_next;
            text_length_field_reg     <= text_length_field_next;
            ctr_reg      <= ctr_next;
            aad_cnt_reg  <= aad_cnt_next;
            c_cnt_reg    <= c_cnt_next;
            rdata_reg    <= rdata_next;
            key_reg      <= key_next;
            iv_reg       <= iv_next;
            input_data_field_reg    <= input_data_field_next;
            odata_reg    <= odata_next;
            hash_state_value_reg    <= hash_state_value_next;
            hsub_reg     <= hsub_next;
            x_reg        <= x_next;
        end
    end

    sequence s_text_block;
        st_reg == ST_BLOCK && !is_aad && mode_reg[`GFP_MODE_GCM];
    endsequence

    a_key_subkey_ready: assert property (@(posedge CLK) disable iff (RST)
        (key_trig && st_reg == ST_IDLE) |-> ##2 (dready_reg && st_reg == ST_IDLE))
        else $error("subkey not ready two cycles after key load");
    a_block_sets_ready: assert property (@(posedge CLK) disable iff (RST)
        (st_reg == ST_BLOCK) |-> ##[130:262] dready_reg)
        else $error("data ready not raised after a block");
    a_aad_no_output: assert property (@(posedge CLK) disable iff (RST)
        (st_reg == ST_BLOCK && is_aad) |=> ($stable(odata_reg) && $stable(ctr_reg)))
        else $error("authenticated-data block changed output or counter");
    a_hash_state_kept: assert property (@(posedge CLK) disable iff (RST)
        (st_reg == ST_WAIT && mif.done) |=> hash_state_value_reg == $past(mif.y))
        else $error("hash state not updated from the multiplier");
    a_text_counter_step: assert property (@(posedge CLK) disable iff (RST)
        s_text_block |=> ctr_reg == $past(ctr_reg) + 32'h1)
        else $error("text block did not advance the counter by one");
    a_single_len_pass: assert property (@(posedge CLK) disable iff (RST)
        (st_reg == ST_BLOCK && auth_data_length_field_reg == `GFP_BLK_BYTES && text_length_field_reg == 32'h0 &&
         aad_cnt_reg == 32'h0 && !mode_reg[`GFP_MODE_TAG])
        |=> (mif.start ##129 (mif.done && st_reg == ST_WAIT)) ##1 st_reg == ST_IDLE)
        else $error("length-block pass was not exactly one hash pass");
endmodule

// *** testbench/gfp_engine_bench.sv ***
// Self-checking bench for the GCM fragment engine over its register port
`timescale 1ns/1ps
`include "gfp_defines.svh"
module gfp_engine_bench;
    import gfp_pkg::*;

    logic       clk;
    logic       rst;
    gfp_addr_t  addr;
    gfp_word_t  wdata;
    logic       wr_stb;
    logic       rd_stb;
    gfp_word_t  rdata;
    logic       irq;
    int         errors;
    int         cmp_count;
    gfp_word_t  d;
    gfp_block_t h_val;
    gfp_block_t iv_val;
    gfp_block_t g;
    gfp_block_t o_pre;
    gfp_block_t o_now;
    gfp_block_t len_blk;

    gfp_engine dut_u (
        .CLK   (clk),
        .RST   (rst),
        .ADDR  (addr),
        .WDATA (wdata),
        .WR    (wr_stb),
        .RD    (rd_stb),
        .RDATA (rdata),
        .IRQ   (irq)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Own field multiply, bit 127 first, so no design function is reused
    function automatic gfp_block_t gmul(input gfp_block_t x, input gfp_block_t y);
        gfp_block_t z;
        gfp_block_t v;
        z = '0;
        v = y;
        for (int i = 127; i >= 0; i--) begin
            if (x[i]) z ^= v;
            v = v[0] ? ((v >> 1) ^ `GFP_GF_POLY) : (v >> 1);
        end
        return z;
    endfunction

    task automatic finish_test;
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input gfp_block_t seen, input gfp_block_t exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobe drops on the edge that samples it; next access waits one edge
    task automatic reg_wr(input gfp_addr_t a, input gfp_word_t v);
        @(posedge clk);
        addr   <= a;
        wdata  <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic reg_rd(input gfp_addr_t a, output gfp_word_t v);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask

    // Word at +0 carries the top bits; the +c write triggers the action
    task automatic wr128(input gfp_addr_t base, input gfp_block_t b);
        for (int k = 0; k < 4; k++)
            reg_wr(base + 8'(4 * k), b[127 - 32 * k -: 32]);
    endtask

    task automatic rd128(input gfp_addr_t base, output gfp_block_t b);
        gfp_word_t w;
        for (int k = 0; k < 4; k++) begin
            reg_rd(base + 8'(4 * k), w);
            b[127 - 32 * k -: 32] = w;
        end
    endtask

    // Bounded wait on the interrupt, then read-clear and see it drop
    task automatic wait_rdy(input int lo, input int hi);
        int n;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 400) begin
                errors++;
                finish_test();
            end
        end
        check(n >= lo && n <= hi, 1'b1);
        reg_rd(`GFP_A_STAT, d);
        check(d, 32'h0000_0001);
        @(posedge clk);
        check(irq, 1'b0);
    endtask

    initial begin
        rst     = 1'b1;
        addr    = 8'h00;
        wdata   = 32'h0;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        errors  = 0;
        cmp_count = 0;
        h_val   = 128'h66e9_4bd4_ef8a_2c3b_884c_fa59_ca34_2b2e;
        iv_val  = 128'hcafe_babe_face_dbad_decaf888_ffff_fffe;
        len_blk = {64'h0000_0000_0000_0080, 64'h0000_0000_0000_0100};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        reg_rd(`GFP_A_STAT, d);
        check(d, 32'h0);
        reg_rd(`GFP_A_CTR, d);
        check(d, 32'h0);
        reg_wr(8'hfc, 32'h1234_5678);
        reg_rd(8'hfc, d);
        check(d, 32'h0);
        // Key load with mask off: flag set, line stays low
        reg_wr(`GFP_A_MODE, 32'h0000_0001);
        wr128(8'h20, 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f);
        repeat (6) @(posedge clk);
        check(irq, 1'b0);
        reg_rd(`GFP_A_STAT, d);
        check(d, 32'h0000_0001);
        reg_rd(`GFP_A_STAT, d);
        check(d, 32'h0);
        reg_wr(`GFP_A_IMASK, 32'h0000_0001);
        wr128(8'h20, 128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100);
        wait_rdy(1, 5);
        wr128(8'h70, h_val);
        rd128(8'h70, g);
        check(g, h_val);
        // First fragment: one AAD block, one text block, remaining lengths
        reg_wr(`GFP_A_MODE, 32'h0000_000d);
        reg_wr(`GFP_A_AUTH_DATA_LENGTH_FIELD, 32'h0000_0010);
        reg_wr(`GFP_A_TEXT_LENGTH_FIELD, 32'h0000_0020);
        wr128(8'h30, iv_val);
        g = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
        wr128(8'h60, g);
        rd128(8'h50, o_pre);
        wr128(8'h40, 128'hfeed_face_dead_beef_feed_face_dead_beef);
        wait_rdy(128, 136);
        rd128(8'h50, o_now);
        check(o_now, o_pre);
        reg_rd(`GFP_A_CTR, d);
        check(d, iv_val[31:0]);
        g = gmul(g ^ 128'hfeed_face_dead_beef_feed_face_dead_beef, h_val);
        rd128(8'h60, o_pre);
        check(o_pre, g);
        wr128(8'h40, 128'hd931_3225_f884_06e5_a559_09c5_aff5_269a);
        wait_rdy(128, 136);
        rd128(8'h50, o_now);
        g = gmul(g ^ o_now, h_val);
        rd128(8'h60, o_pre);
        check(o_pre, g);
        reg_rd(`GFP_A_CTR, d);
        check(d, iv_val[31:0] + 32'h1);
        // Continuing fragment starts with text: saved counter, fragment length
        wr128(8'h30, {iv_val[127:32], d});
        reg_wr(`GFP_A_AUTH_DATA_LENGTH_FIELD, 32'h0);
        reg_wr(`GFP_A_TEXT_LENGTH_FIELD, 32'h0000_0010);
        wr128(8'h60, g);
        wr128(8'h40, 128'h86a7_a9531_534f7da_2e4c303d_8a318a72);
        wait_rdy(128, 136);
        rd128(8'h50, o_now);
        g = gmul(g ^ o_now, h_val);
        rd128(8'h60, o_pre);
        check(o_pre, g);
        reg_rd(`GFP_A_CTR, d);
        check(d, 32'(iv_val[31:0] + 32'h2));
        // Manual tag step: manual start, one hash pass over the length block
        reg_wr(`GFP_A_MODE, 32'h0000_0005);
        reg_wr(`GFP_A_AUTH_DATA_LENGTH_FIELD, 32'h0000_0010);
        reg_wr(`GFP_A_TEXT_LENGTH_FIELD, 32'h0);
        wr128(8'h30, iv_val);
        wr128(8'h60, g);
        wr128(8'h40, len_blk);
        repeat (10) @(posedge clk);
        check(irq, 1'b0);
        reg_wr(`GFP_A_CTRL, 32'h0000_0001);
        wait_rdy(128, 136);
        rd128(8'h60, o_pre);
        check(o_pre, gmul(g ^ len_blk, h_val));
        rd128(8'h50, o_pre);
        check(o_pre, o_now);
        reg_rd(`GFP_A_CTR, d);
        check(d, iv_val[31:0]);
        // Zero text at counter 1, so the output is the tag pad itself
        reg_wr(`GFP_A_MODE, 32'h0000_000d);
        reg_wr(`GFP_A_AUTH_DATA_LENGTH_FIELD, 32'h0);
        reg_wr(`GFP_A_TEXT_LENGTH_FIELD, 32'h0000_0010);
        wr128(8'h30, {iv_val[127:32], 32'h0000_0001});
        wr128(8'h40, 128'h0);
        wait_rdy(128, 136);
        rd128(8'h50, o_pre);
        reg_rd(`GFP_A_CTR, d);
        check(d, 32'h0000_0002);
        // Decrypt with auto tag: input hashed, then length pass, tag in output
        reg_wr(`GFP_A_MODE, 32'h0000_000b);
        reg_rd(`GFP_A_MODE, d);
        check(d, 32'h0000_000b);
        wr128(8'h30, {iv_val[127:32], 32'h0000_0002});
        rd128(8'h30, g);
        check(g, {iv_val[127:32], 32'h0000_0002});
        wr128(8'h60, 128'h0);
        wr128(8'h40, len_blk);
        wait_rdy(256, 270);
        g = gmul(gmul(len_blk, h_val) ^ {64'h0, 64'h0000_0000_0000_0080}, h_val);
        rd128(8'h60, o_now);
        check(o_now, g);
        rd128(8'h50, o_now);
        check(o_now, g ^ o_pre);
        reg_rd(`GFP_A_CTR, d);
        check(d, 32'h0000_0003);
        reg_rd(`GFP_A_IMASK, d);
        check(d, 32'h0000_0001);
        // Reset with the engine idle after the last block brings registers and line back to idle
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reg_rd(`GFP_A_MODE, d);
        check(d, 32'h0);
        reg_rd(`GFP_A_IMASK, d);
        check(d, 32'h0);
        reg_rd(`GFP_A_TEXT_LENGTH_FIELD, d);
        check(d, 32'h0);
        check(irq, 1'b0);
        finish_test();
    end
endmodule
